// ---- hdl/gpm_defines.svh ----
// Constants for the low-voltage port mux: counts, codes, reset values
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH
`define GPM_NUM_PORTS 11
`define GPM_NUM_ADC 5
`define GPM_NUM_ALT_SRC 11
`define GPM_IN_FLOAT 2'h0
`define GPM_IN_PULLUP 2'h1
`define GPM_IN_PULLDOWN 2'h2
`define GPM_IN_ANALOG 2'h3
`define GPM_ANALOG_MASK 11'h30F
`define GPM_CFG_RESET 6'h00
`define GPM_AIS_RESET 8'h00
`define GPM_SRC_CMP0 4'h0
`define GPM_SRC_CMP1 4'h1
`define GPM_SRC_CMP2 4'h2
`define GPM_SRC_TMR0 4'h3
`define GPM_SRC_TMR1 4'h4
`define GPM_SRC_TRACE 4'h5
`define GPM_SRC_UTX 4'h6
`define GPM_SRC_PULSE 4'h7
`define GPM_SRC_SCS 4'h8
`define GPM_SRC_SCK 4'h9
`define GPM_SRC_MOSI 4'hA
`endif

// ---- hdl/gpm_pkg.sv ----
// Types for the low-voltage port mux
`include "gpm_defines.svh"
package gpm_pkg;
  typedef enum logic [1:0] {
    GPM_FLOAT = `GPM_IN_FLOAT,
    GPM_PULLUP = `GPM_IN_PULLUP,
    GPM_PULLDOWN = `GPM_IN_PULLDOWN,
    GPM_ANALOG = `GPM_IN_ANALOG
  } gpm_in_mode_e;

  // Per-port setting
  typedef struct packed {
    gpm_in_mode_e in_mode;
    logic drive_en;
    logic open_drain;
    logic use_alt;
    logic alt_sel;
  } gpm_port_cfg_s;

  // Source choice for shared peripheral inputs, 0 picks the first port
  typedef struct packed {
    logic [2:0] capture;
    logic [1:0] timer;
    logic uart_rx;
    logic miso;
    logic pulse_in;
  } gpm_ais_s;
endpackage : gpm_pkg

// ---- hdl/gpm_port_mux.sv ----
// Eleven low-voltage I/O ports with output, input and analog function mux
// Contract
// [RQ1] Eleven ports, 0 to 10, each configured on its own.
// [RQ2] Each port offers floating, weak pull-up and weak pull-down inputs.
// [RQ3] Analog input only on ports 0-3 and the 8/9 pair.
// [RQ4] Digital input mode puts the sampled pin level into the data-input bit.
// [RQ5] Analog mode routes pin to converter channel; data-input bit reads zero.
// [RQ6] Each port drives push-pull or open-drain.
// [RQ7] Each port chooses normal or alternate output on its own.
// [RQ8] Normal output drives the data-output register bit.
// [RQ9] Alternate output drives one of two peripheral signals, chosen per port.
// [RQ10] Alternate pairs for ports 0 to 5 as tabled.
// [RQ11] Alternate pairs for ports 6 to 10 as tabled.
// [RQ12] Pin levels feed capture, timer, receive, MISO and pulse inputs.
// [RQ13] Shared peripheral inputs pick their source port by select setting.
// [RQ14] Reset gives floating inputs, drivers off, first sources; analog never drives.
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_port_mux (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Port settings
  input wire gpm_pkg::gpm_port_cfg_s [`GPM_NUM_PORTS-1:0] port_cfg,
  input wire logic [`GPM_NUM_PORTS-1:0] port_data_out_reg,
  input wire gpm_pkg::gpm_ais_s alt_input_source_select,
  // Peripheral outputs
  input wire logic [2:0] compare_channel_out,
  input wire logic [1:0] general_timer_out,
  input wire logic trace_serial_out,
  input wire logic lin_serial_transmit,
  input wire logic pulse_io_out,
  input wire logic spi_chip_select,
  input wire logic spi_clock,
  input wire logic spi_mosi,
  // Peripheral inputs
  output logic [2:0] capture_channel_in,
  output logic [1:0] general_timer_in,
  output logic lin_serial_receive,
  output logic spi_miso,
  output logic pulse_io_in,
  // Data-input register and converter routing
  output logic [`GPM_NUM_PORTS-1:0] port_data_in_reg,
  output logic [`GPM_NUM_ADC-1:0] converter_channel_input,
  // Pads
  input wire logic [`GPM_NUM_PORTS-1:0] pin_in,
  output logic [`GPM_NUM_PORTS-1:0] pin_out,
  output logic [`GPM_NUM_PORTS-1:0] pin_oe_b,
  output logic [`GPM_NUM_PORTS-1:0] pull_up_en,
  output logic [`GPM_NUM_PORTS-1:0] pull_down_en,
  output logic [`GPM_NUM_PORTS-1:0] analog_en
);

  // Alternate output source per port and choice
  function automatic logic [3:0] alt_index(input int unsigned port, input logic sel);
    logic [3:0] idx;
    idx = `GPM_SRC_CMP0;
    unique case (port)
      0: idx = sel ? `GPM_SRC_TMR0 : `GPM_SRC_CMP0; // RQ10
      1: idx = sel ? `GPM_SRC_TMR1 : `GPM_SRC_CMP1; // RQ10
      2: idx = sel ? `GPM_SRC_TRACE : `GPM_SRC_CMP2; // RQ10
      3: idx = sel ? `GPM_SRC_TRACE : `GPM_SRC_TMR0; // RQ10
      4: idx = sel ? `GPM_SRC_UTX : `GPM_SRC_TMR1; // RQ10
      5: idx = sel ? `GPM_SRC_CMP0 : `GPM_SRC_TRACE; // RQ10
      6: idx = sel ? `GPM_SRC_CMP1 : `GPM_SRC_PULSE; // RQ11
      7: idx = sel ? `GPM_SRC_CMP2 : `GPM_SRC_SCS; // RQ11
      8: idx = sel ? `GPM_SRC_TRACE : `GPM_SRC_SCK; // RQ11
      9: idx = sel ? `GPM_SRC_TRACE : `GPM_SRC_MOSI; // RQ11
      default: idx = sel ? `GPM_SRC_PULSE : `GPM_SRC_UTX; // RQ11
    endcase
    return idx;
  endfunction : alt_index

  gpm_pkg::gpm_port_cfg_s [`GPM_NUM_PORTS-1:0] cfg;
  gpm_pkg::gpm_ais_s ais;
  logic [`GPM_NUM_PORTS-1:0] pin_meta;
  logic [`GPM_NUM_PORTS-1:0] pin_sync;
  logic [`GPM_NUM_PORTS-1:0] is_analog;
  logic [`GPM_NUM_PORTS-1:0] dig_in;
  logic [`GPM_NUM_PORTS-1:0] level;
  logic [`GPM_NUM_PORTS-1:0] drive;
  logic [`GPM_NUM_PORTS-1:0] next_pin_out;
  logic [`GPM_NUM_PORTS-1:0] next_pin_oe_b;
  logic [`GPM_NUM_ALT_SRC-1:0] periph_out;
  logic [2:0] next_capture;
  logic [1:0] next_timer;
  logic next_uart_rx;
  logic next_miso;
  logic next_pulse_in;
  // Ports that have an analog path; a literal cannot be bit-selected
  localparam logic [`GPM_NUM_PORTS-1:0] analog_capable = `GPM_ANALOG_MASK; // RQ3

  // Settings held in flops so reset gives a defined state
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg <= {`GPM_NUM_PORTS{`GPM_CFG_RESET}}; // RQ14
      ais <= `GPM_AIS_RESET; // RQ14
    end
    else
    begin
      cfg <= port_cfg; // RQ1
      ais <= alt_input_source_select;
    end
  end

  // Two-flop pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Peripheral output vector, indexed by source code
  assign periph_out = {spi_mosi, spi_clock, spi_chip_select, pulse_io_out, lin_serial_transmit,
                       trace_serial_out, general_timer_out, compare_channel_out};

  // Per-port decode of input mode and output level
  genvar gi;
  generate
    for (gi = 0; gi < `GPM_NUM_PORTS; gi++)
    begin : g_port
      wire logic [3:0] src = alt_index(gi, cfg[gi].alt_sel); // RQ9
      // Analog only where the port supports it, otherwise floating
      assign is_analog[gi] = (cfg[gi].in_mode == gpm_pkg::GPM_ANALOG) & analog_capable[gi]; // RQ3
      assign pull_up_en[gi] = (cfg[gi].in_mode == gpm_pkg::GPM_PULLUP); // RQ2
      assign pull_down_en[gi] = (cfg[gi].in_mode == gpm_pkg::GPM_PULLDOWN); // RQ2
      assign dig_in[gi] = pin_sync[gi] & ~is_analog[gi]; // RQ5
      assign level[gi] = cfg[gi].use_alt ? periph_out[src] : port_data_out_reg[gi]; // RQ7 RQ8
      assign drive[gi] = cfg[gi].drive_en & ~is_analog[gi]; // RQ14
      // Open-drain drives low only and releases for a one
      assign next_pin_out[gi] = level[gi] & ~cfg[gi].open_drain; // RQ6
      assign next_pin_oe_b[gi] = ~(drive[gi] & (~cfg[gi].open_drain | ~level[gi])); // RQ6
    end
  endgenerate

  assign analog_en = is_analog;

  // Converter routing; channel 4 needs both halves of the pair
  assign converter_channel_input = {is_analog[8] & is_analog[9], is_analog[3:0]}; // RQ5

  // Shared peripheral input selection
  assign next_capture[0] = ais.capture[0] ? dig_in[5] : dig_in[0]; // RQ12 RQ13
  assign next_capture[1] = ais.capture[1] ? dig_in[6] : dig_in[1]; // RQ12 RQ13
  assign next_capture[2] = ais.capture[2] ? dig_in[7] : dig_in[2]; // RQ12 RQ13
  assign next_timer[0] = ais.timer[0] ? dig_in[3] : dig_in[0]; // RQ12 RQ13
  assign next_timer[1] = ais.timer[1] ? dig_in[4] : dig_in[1]; // RQ12 RQ13
  assign next_uart_rx = ais.uart_rx ? dig_in[9] : dig_in[3]; // RQ12 RQ13
  assign next_miso = ais.miso ? dig_in[10] : dig_in[4]; // RQ12 RQ13
  assign next_pulse_in = ais.pulse_in ? dig_in[9] : dig_in[5]; // RQ12 RQ13

  // Registered input side
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_data_in_reg <= '0;
      capture_channel_in <= '0;
      general_timer_in <= '0;
      lin_serial_receive <= 1'b0;
      spi_miso <= 1'b0;
      pulse_io_in <= 1'b0;
    end
    else
    begin
      port_data_in_reg <= dig_in; // RQ4 RQ5
      capture_channel_in <= next_capture;
      general_timer_in <= next_timer;
      lin_serial_receive <= next_uart_rx;
      spi_miso <= next_miso;
      pulse_io_in <= next_pulse_in;
    end
  end

  // Registered pad drive, released during reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out <= '0;
      pin_oe_b <= '1; // RQ14
    end
    else
    begin
      pin_out <= next_pin_out; // RQ8
      pin_oe_b <= next_pin_oe_b;
    end
  end

  // Per-port checks
  generate
    for (gi = 0; gi < `GPM_NUM_PORTS; gi++)
    begin : g_chk
      chk_analog_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ5
        is_analog[gi] |=> !port_data_in_reg[gi])
        else $error("data-in bit set while port analog");
      chk_digital_in_follows: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ4
        !is_analog[gi] |=> port_data_in_reg[gi] == $past(pin_sync[gi]))
        else $error("data-in bit does not follow pin");
      chk_analog_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ14
        is_analog[gi] |=> pin_oe_b[gi])
        else $error("analog port drives its pin");
      chk_normal_pushpull: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ8
        (cfg[gi].drive_en && !cfg[gi].use_alt && !cfg[gi].open_drain && !is_analog[gi])
        |=> (!pin_oe_b[gi] && pin_out[gi] == $past(port_data_out_reg[gi])))
        else $error("normal output level wrong");
      chk_open_drain_high: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ6
        (cfg[gi].open_drain && !cfg[gi].use_alt && port_data_out_reg[gi])
        |=> (pin_oe_b[gi] && !pin_out[gi]))
        else $error("open-drain drives a one");
      chk_pull_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ2
        !(pull_up_en[gi] && pull_down_en[gi]))
        else $error("pull-up and pull-down both on");
      chk_alt_drives_pin: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ9
        (cfg[gi].drive_en && cfg[gi].use_alt && !cfg[gi].open_drain && !is_analog[gi])
        |=> !pin_oe_b[gi])
        else $error("alternate output not driven");
      chk_open_drain_low: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ6
        (cfg[gi].drive_en && cfg[gi].open_drain && !cfg[gi].use_alt && !port_data_out_reg[gi] && !is_analog[gi])
        |=> (!pin_oe_b[gi] && !pin_out[gi]))
        else $error("open-drain zero not driven low");
      chk_driver_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ14
        !cfg[gi].drive_en |=> pin_oe_b[gi])
        else $error("disabled driver drives its pin");
    end
  endgenerate

  chk_no_analog_port4: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ3
    !analog_en[4] && !analog_en[7] && !analog_en[10])
    else $error("analog on unsupported port");
  chk_port4_alt_tx: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ10
    (cfg[4].drive_en && cfg[4].use_alt && cfg[4].alt_sel && !cfg[4].open_drain)
    |=> pin_out[4] == $past(lin_serial_transmit))
    else $error("port 4 alternate 1 is not transmit");
  chk_port6_alt_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ11
    (cfg[6].drive_en && cfg[6].use_alt && !cfg[6].alt_sel && !cfg[6].open_drain)
    |=> pin_out[6] == $past(pulse_io_out))
    else $error("port 6 alternate 0 is not pulse output");
  chk_capture_select: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.capture[0] |=> capture_channel_in[0] == $past(dig_in[5]))
    else $error("capture 0 source wrong");
  chk_uart_rx_source: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.uart_rx |=> lin_serial_receive == $past(dig_in[3]))
    else $error("receive source wrong");
  chk_pair_channel: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ5
    converter_channel_input[4] == (analog_en[8] && analog_en[9]))
    else $error("pair channel routing wrong");

  // Second-source input selections
  chk_capture1_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.capture[1] |=> capture_channel_in[1] == $past(dig_in[6]))
    else $error("capture 1 second source wrong");
  chk_capture2_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.capture[2] |=> capture_channel_in[2] == $past(dig_in[7]))
    else $error("capture 2 second source wrong");
  chk_timer0_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.timer[0] |=> general_timer_in[0] == $past(dig_in[3]))
    else $error("timer 0 second source wrong");
  chk_timer1_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.timer[1] |=> general_timer_in[1] == $past(dig_in[4]))
    else $error("timer 1 second source wrong");
  chk_uart_rx_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.uart_rx |=> lin_serial_receive == $past(dig_in[9]))
    else $error("receive second source wrong");
  chk_miso_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.miso |=> spi_miso == $past(dig_in[10]))
    else $error("miso second source wrong");
  chk_pulse_in_alt: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ13
    ais.pulse_in |=> pulse_io_in == $past(dig_in[9]))
    else $error("pulse input second source wrong");

  // First-source input selections
  chk_capture0_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.capture[0] |=> capture_channel_in[0] == $past(dig_in[0]))
    else $error("capture 0 first source wrong");
  chk_capture1_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.capture[1] |=> capture_channel_in[1] == $past(dig_in[1]))
    else $error("capture 1 first source wrong");
  chk_capture2_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.capture[2] |=> capture_channel_in[2] == $past(dig_in[2]))
    else $error("capture 2 first source wrong");
  chk_timer0_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.timer[0] |=> general_timer_in[0] == $past(dig_in[0]))
    else $error("timer 0 first source wrong");
  chk_timer1_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.timer[1] |=> general_timer_in[1] == $past(dig_in[1]))
    else $error("timer 1 first source wrong");
  chk_miso_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.miso |=> spi_miso == $past(dig_in[4]))
    else $error("miso first source wrong");
  chk_pulse_in_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ12
    !ais.pulse_in |=> pulse_io_in == $past(dig_in[5]))
    else $error("pulse input first source wrong");

endmodule : gpm_port_mux

// ---- verif/gpm_board_model.sv ----
// Board model: resolves each pin from pad drive, board drivers and pulls
`timescale 1ns/1ps
module gpm_board_model (
  // Clock
  input wire logic ref_clk,
  // Pad side of the block
  input wire logic [10:0] pin_out,
  input wire logic [10:0] pin_oe_b,
  input wire logic [10:0] pull_up_en,
  input wire logic [10:0] pull_down_en,
  // Board drivers
  input wire logic [10:0] ext_en,
  input wire logic [10:0] ext_val,
  // Resolved pin levels
  output logic [10:0] pin_in
);
  logic wander = 1'b0;

  // Undriven, unpulled pin changes every cycle so it never looks settled
  always @(posedge ref_clk) wander <= ~wander;

  // Pad driver wins, then board driver, then pulls
  always_comb
    for (int i = 0; i < 11; i++)
      pin_in[i] = !pin_oe_b[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : wander;
endmodule : gpm_board_model

// ---- verif/test_gpm_port_mux.sv ----
// Self-checking bench for the low-voltage port mux
`timescale 1ns/1ps
`include "gpm_defines.svh"
module test_gpm_port_mux;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  gpm_pkg::gpm_port_cfg_s [10:0] port_cfg = '0;
  gpm_pkg::gpm_ais_s ais = '0;
  logic [10:0] dout = '0, src = '0, ext_en = '0, ext_val = '0, pin_in;
  logic [10:0] pin_out, pin_oe_b, pu, pd, an, din;
  logic [2:0] cap;
  logic [1:0] tmr;
  logic rx, miso, pls;
  logic [4:0] conv;
  logic [3:0] a0 [11] = '{`GPM_SRC_CMP0, `GPM_SRC_CMP1, `GPM_SRC_CMP2, `GPM_SRC_TMR0, `GPM_SRC_TMR1,
    `GPM_SRC_TRACE, `GPM_SRC_PULSE, `GPM_SRC_SCS, `GPM_SRC_SCK, `GPM_SRC_MOSI, `GPM_SRC_UTX};
  logic [3:0] a1 [11] = '{`GPM_SRC_TMR0, `GPM_SRC_TMR1, `GPM_SRC_TRACE, `GPM_SRC_TRACE, `GPM_SRC_UTX,
    `GPM_SRC_CMP0, `GPM_SRC_CMP1, `GPM_SRC_CMP2, `GPM_SRC_TRACE, `GPM_SRC_TRACE, `GPM_SRC_PULSE};
  int n_mismatch = 0, n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  gpm_port_mux u_gpm_port_mux (.ref_clk(ref_clk), .rst_b(rst_b), .port_cfg(port_cfg),
    .port_data_out_reg(dout), .alt_input_source_select(ais), .compare_channel_out(src[2:0]),
    .general_timer_out(src[4:3]), .trace_serial_out(src[5]), .lin_serial_transmit(src[6]),
    .pulse_io_out(src[7]), .spi_chip_select(src[8]), .spi_clock(src[9]), .spi_mosi(src[10]),
    .capture_channel_in(cap), .general_timer_in(tmr), .lin_serial_receive(rx), .spi_miso(miso),
    .pulse_io_in(pls), .port_data_in_reg(din), .converter_channel_input(conv), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pull_up_en(pu), .pull_down_en(pd), .analog_en(an));

  gpm_board_model u_gpm_board_model (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .pull_up_en(pu), .pull_down_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Config flop, pad flop, two sync flops and data-in flop, then sample off the edge
  task automatic settle();
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  task automatic set_cfg(input logic [1:0] m, input logic [3:0] ctl);
    for (int i = 0; i < 11; i++) port_cfg[i] = {m, ctl};
  endtask : set_cfg

  task automatic t_reset();
    repeat (20) @(negedge ref_clk);
    chk(pin_oe_b, 11'h7FF, "oe in reset");
    rst_b = 1'b1;
    settle();
    chk(pin_oe_b, 11'h7FF, "oe after reset");
    chk(pu | pd | an, 11'h000, "pulls after reset");
  endtask : t_reset

  task automatic t_outputs();
    set_cfg(2'h0, 4'h8);
    dout = 11'h5A5;
    settle();
    chk(pin_out, 11'h5A5, "normal data");
    chk(pin_oe_b, 11'h000, "push-pull enable");
    dout = 11'h7FF;
    for (int i = 0; i < 11; i++) port_cfg[i] = i[0] ? 6'h08 : 6'h0C;
    settle();
    chk(pin_oe_b, 11'h555, "open-drain high released");
    dout = 11'h000;
    settle();
    chk(pin_oe_b | pin_out, 11'h000, "open-drain low driven");
  endtask : t_outputs

  task automatic t_alt();
    logic [10:0] exp;
    for (int s = 0; s < 2; s++)
    begin
      set_cfg(2'h0, {3'h5, s[0]});
      for (int k = 0; k < 11; k++)
      begin
        src = 11'h001 << k;
        for (int p = 0; p < 11; p++) exp[p] = ((s != 0) ? a1[p] : a0[p]) == k[3:0];
        settle();
        chk(pin_out, exp, "alternate output");
      end
    end
    src = '0;
  endtask : t_alt

  task automatic t_inputs();
    logic [10:0] p;
    logic [7:0] e;
    set_cfg(2'h1, 4'h0);
    settle();
    chk(din, 11'h7FF, "pull-up level");
    set_cfg(2'h2, 4'h0);
    settle();
    chk(din, 11'h000, "pull-down level");
    set_cfg(2'h0, 4'h0);
    ext_en = 11'h7FF;
    for (int v = 0; v < 4; v++)
    begin
      p = v[0] ? 11'h2B6 : 11'h549;
      ext_val = p;
      ais = v[1] ? 8'hFF : 8'h00;
      e = v[1] ? {p[7], p[6], p[5], p[4], p[3], p[9], p[10], p[9]} : {p[2], p[1], p[0], p[1], p[0], p[3], p[4], p[5]};
      settle();
      chk(din, p, "data-in level");
      chk({3'h0, cap, tmr, rx, miso, pls}, {3'h0, e}, "peripheral inputs");
    end
  endtask : t_inputs

  task automatic t_analog();
    set_cfg(2'h3, 4'h8);
    dout = 11'h7FF;
    ext_val = 11'h7FF;
    settle();
    chk(an, 11'h30F, "analog ports");
    chk({6'h00, conv}, 11'h01F, "converter routing");
    chk(din, 11'h4F0, "analog data-in zero");
    chk(pin_oe_b, 11'h30F, "analog not driven");
    port_cfg[9].in_mode = gpm_pkg::GPM_FLOAT;
    settle();
    chk({6'h00, conv}, 11'h00F, "pair needs both");
    rst_b = 1'b0;
    #1;
    chk(pin_oe_b, 11'h7FF, "mid-run reset");
    @(negedge ref_clk);
    rst_b = 1'b1;
    settle();
    chk(an, 11'h10F, "settings reload after reset");
  endtask : t_analog

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial
  begin
    #100us;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    t_reset();
    t_outputs();
    t_alt();
    t_inputs();
    t_analog();
    summarize();
  end
endmodule : test_gpm_port_mux
